// [common/acf_defines.vh]
// Purpose: Constants for the ancillary insertion line configuration store.
// Assumes: Word addresses are 9 bits wide on the serial host port.
// Notes:   Offsets are word addresses, as the host port carries them.
`ifndef ACF_DEFINES_VH
`define ACF_DEFINES_VH

// ****************************************************************
// Register map
// ****************************************************************
`define ACF_ADDR_W        9
`define ACF_ADDR_MODE     9'h020
`define ACF_ADDR_L1_ATTR  9'h021
`define ACF_ADDR_L2_NUM   9'h022
`define ACF_ADDR_L2_ATTR  9'h023
`define ACF_ADDR_L3_NUM   9'h024
`define ACF_ADDR_L3_ATTR  9'h025
`define ACF_ADDR_L4_NUM   9'h026
`define ACF_ADDR_L4_ATTR  9'h027
`define ACF_CFG_PAGE      6'h04
`define ACF_BANK_ONE      9'h040
`define ACF_BANK_TWO      9'h080
`define ACF_BANK_THREE    9'h0c0
`define ACF_BANK_FOUR     9'h100
`define ACF_BANK_END      9'h13f

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define ACF_MODE_BIT      15
`define ACF_SPACE_BIT     15
`define ACF_STREAM_BIT    14
`define ACF_CNT_MSB       9
`define ACF_LINE_MSB      10
`define ACF_HI_MSB        15
`define ACF_HI_LSB        8
`define ACF_LO_MSB        7
`define ACF_FLAGS_MASK    16'h9fff
`define ACF_REG_RESET     16'h0000

// ****************************************************************
// Serial host port framing and reset hold time
// ****************************************************************
`define ACF_RW_BIT        15
`define ACF_WORD_BITS     5'h10
`define ACF_RESET_HOLD_MS 10
`define ACF_CLK_MHZ       100
`define ACF_RESET_CYCLES  (`ACF_RESET_HOLD_MS * 1000 * `ACF_CLK_MHZ)

`endif

// [rtl/acf_line_config.v]
// Purpose: Ancillary insertion line configuration and payload streamer.
// Assumes: Host port pins are asynchronous and sampled with two flops.
// Notes:   Scan mode offers a one-bit bypass path only.
//
// Functional notes
// R1 - Bit 15 selects horizontal or vertical space.
// R2 - Bit 14 selects luma or chroma stream.
// R3 - Standard definition ignores stream select bit.
// R4 - First entry bits 9-0 give word count.
// R5 - Lines two to four number in 10-0.
// R6 - Lines two to four count in 9-0.
// R7 - Payload write-only, high byte 15-8, low 7-0.
// R8 - Four 64-word banks at 040h through 13Fh.
// R9 - Host holds reset at least 10 ms.
// R10 - Outputs high impedance while reset is held.
// R11 - Test select turns host port into scan.
// R12 - In scan mode reset acts as test reset.
// R13 - Tester keeps rate select low during scan.
// R14 - Word 020h bit 15 selects insertion mode.
// R15 - Word 020h bits 10-0 first line number.
// R16 - Stream ascending, high byte first, line by line.
// R17 - Reserved bits writable, inert, reset zero; word 020h bits 14-13 are masked on write and stay zero.
`timescale 1ns/100ps
`include "acf_defines.vh"

module acf_line_config (
    input  wire        clk,
    input  wire        reset,
    input  wire        host_cs_n,
    input  wire        host_sclk,
    input  wire        host_sdin,
    output reg         host_sdout,
    output reg         host_sdout_oe,
    input  wire        test_select,
    input  wire        definition_rate_select,
    input  wire        insert_start,
    input  wire        anc_ready,
    output reg         anc_valid,
    output reg  [7:0]  anc_byte,
    output reg  [10:0] anc_line_number,
    output reg         anc_space_select,
    output reg         anc_chroma_select,
    output reg         anc_last,
    output reg         anc_out_oe,
    output reg         insert_busy
);

    localparam W_IDLE  = 3'd0;
    localparam W_LINE  = 3'd1;
    localparam W_FETCH = 3'd2;
    localparam W_WAIT  = 3'd3;
    localparam W_PUSH  = 3'd4;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    reg [2:0] sclk_sync_reg;
    reg [1:0] cs_sync_reg;
    reg [1:0] sdin_sync_reg;
    reg [1:0] test_sync_reg;
    reg [1:0] rate_sync_reg;

    // These carry no reset so that the scan strap is seen during reset.
    always @(posedge clk) begin
        sclk_sync_reg <= {sclk_sync_reg[1:0], host_sclk};
        cs_sync_reg   <= {cs_sync_reg[0], host_cs_n};
        sdin_sync_reg <= {sdin_sync_reg[0], host_sdin};
        test_sync_reg <= {test_sync_reg[0], test_select};
        rate_sync_reg <= {rate_sync_reg[0], definition_rate_select};
    end

    wire scan_mode = test_sync_reg[1];
    wire sd_mode   = rate_sync_reg[1];
    wire cs_active = ~cs_sync_reg[1];
    wire sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
    wire sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
    wire host_bit  = sdin_sync_reg[1];

    // In scan mode the shared reset only clears the test logic.
    wire func_reset = reset & ~scan_mode; // see R12

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    // Index k holds word 020h+2k (number) and 021h+2k (attributes).
    reg [15:0] lnum_reg [0:3];
    reg [15:0] attr_reg [0:3];

    function is_cfg;
        input [8:0] a;
        begin
            is_cfg = (a[8:3] == `ACF_CFG_PAGE);
        end
    endfunction

    function is_bank;
        input [8:0] a;
        begin
            is_bank = (a >= `ACF_BANK_ONE) && (a <= `ACF_BANK_END); // see R8
        end
    endfunction

    // ****************************************************************
    // Serial host port
    // ****************************************************************
    reg        data_phase_reg;
    reg        cmd_read_reg;
    reg [8:0]  cmd_addr_reg;
    reg [4:0]  bit_cnt_reg;
    reg [15:0] in_sh_reg;
    reg [15:0] out_sh_reg;
    reg        host_wr_reg;
    reg [15:0] host_wdata_reg;
    reg [8:0]  host_waddr_reg;
    reg        bypass_reg;
    reg [15:0] rd_word;
    reg [15:0] wr_word;

    always @* begin
        wr_word = {in_sh_reg[14:0], host_bit};
        rd_word = 16'h0000;
        // Payload banks are write-only and read back as zero.
        if (is_cfg(cmd_addr_reg)) begin // see R7
            if (cmd_addr_reg[0])
                rd_word = attr_reg[cmd_addr_reg[2:1]];
            else
                rd_word = lnum_reg[cmd_addr_reg[2:1]];
        end
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            data_phase_reg <= 1'b0;
            cmd_read_reg   <= 1'b0;
            cmd_addr_reg   <= 9'h000;
            bit_cnt_reg    <= 5'h00;
            in_sh_reg      <= 16'h0000;
            out_sh_reg     <= 16'h0000;
            host_wr_reg    <= 1'b0;
            host_wdata_reg <= 16'h0000;
            host_waddr_reg <= 9'h000;
            host_sdout     <= 1'b0;
            host_sdout_oe  <= 1'b0; // see R10
            bypass_reg     <= 1'b0;
        end else begin
            host_wr_reg <= 1'b0;
            if (scan_mode) begin
                // Clock is tck, select is tms, data in is tdi.
                data_phase_reg <= 1'b0;
                bit_cnt_reg    <= 5'h00;
                host_sdout_oe  <= 1'b1; // see R11
                if (sclk_rise)
                    bypass_reg <= host_bit;
                if (sclk_fall)
                    host_sdout <= bypass_reg;
            end else if (!cs_active) begin
                data_phase_reg <= 1'b0;
                bit_cnt_reg    <= 5'h00;
                host_sdout_oe  <= 1'b0;
            end else begin
                host_sdout_oe <= data_phase_reg & cmd_read_reg;
                if (sclk_rise) begin
                    in_sh_reg <= wr_word;
                    if (bit_cnt_reg == `ACF_WORD_BITS - 5'h01) begin
                        bit_cnt_reg <= 5'h00;
                        if (!data_phase_reg) begin
                            data_phase_reg <= 1'b1;
                            cmd_read_reg   <= wr_word[`ACF_RW_BIT];
                            cmd_addr_reg   <= wr_word[8:0];
                        end else begin
                            data_phase_reg <= 1'b0;
                            host_wr_reg    <= ~cmd_read_reg;
                            host_wdata_reg <= wr_word;
                            host_waddr_reg <= cmd_addr_reg;
                        end
                    end else begin
                        bit_cnt_reg <= bit_cnt_reg + 5'h01;
                    end
                end
                // Read data are fetched after the address is latched.
                if (data_phase_reg && bit_cnt_reg == 5'h00 && !sclk_rise
                    && sclk_fall == 1'b0 && out_sh_reg == 16'h0000
                    && !host_sdout_oe) begin
                    host_sdout <= rd_word[15];
                    out_sh_reg <= {rd_word[14:0], 1'b0};
                end else if (sclk_fall && data_phase_reg
                             && bit_cnt_reg != 5'h00) begin
                    host_sdout <= out_sh_reg[15];
                    out_sh_reg <= {out_sh_reg[14:0], 1'b0};
                end
                if (!data_phase_reg)
                    out_sh_reg <= 16'h0000;
            end
        end
    end

    // ****************************************************************
    // Register writes
    // ****************************************************************
    integer k;

    always @(posedge clk or posedge func_reset) begin
        if (func_reset) begin
            for (k = 0; k < 4; k = k + 1) begin
                lnum_reg[k] <= `ACF_REG_RESET; // see R17
                attr_reg[k] <= `ACF_REG_RESET;
            end
        end else if (host_wr_reg && is_cfg(host_waddr_reg)) begin
            if (host_waddr_reg[0])
                attr_reg[host_waddr_reg[2:1]] <= host_wdata_reg; // see R17
            else if (host_waddr_reg[2:1] == 2'd0)
                lnum_reg[0] <= host_wdata_reg & `ACF_FLAGS_MASK;
            else
                lnum_reg[host_waddr_reg[2:1]] <= host_wdata_reg;
        end
    end

    wire       mode_concat = lnum_reg[0][`ACF_MODE_BIT]; // see R14
    wire [8:0] bank_index  = host_waddr_reg - `ACF_BANK_ONE;
    wire       mem_wr      = host_wr_reg & is_bank(host_waddr_reg);

    // ****************************************************************
    // Payload store
    // ****************************************************************
    reg        rd_en_reg;
    reg [8:0]  bptr_reg;
    wire [15:0] mem_rdata;

    acf_payload_mem u_mem (
        .clk     (clk),
        .wr_en   (mem_wr),
        .wr_addr (bank_index[7:0]),
        .wr_data (host_wdata_reg),
        .rd_en   (rd_en_reg),
        .rd_addr (bptr_reg[8:1]),
        .rd_data (mem_rdata)
    );

    // ****************************************************************
    // Payload walker
    // ****************************************************************
    reg [2:0]  wstate_reg;
    reg [1:0]  line_reg;
    reg [9:0]  left_reg;
    reg [21:0] push_data;
    wire       buf_in_ready;
    wire       last_line = mode_concat || (line_reg == 2'd3);
    wire [9:0] line_cnt  = attr_reg[line_reg][`ACF_CNT_MSB:0]; // see R4, R6
    wire [7:0] cur_byte  = bptr_reg[0] ? mem_rdata[`ACF_LO_MSB:0]
                           : mem_rdata[`ACF_HI_MSB:`ACF_HI_LSB]; // see R7

    always @* begin
        push_data = {cur_byte,
                     lnum_reg[line_reg][`ACF_LINE_MSB:0], // see R5, R15
                     attr_reg[line_reg][`ACF_SPACE_BIT], // see R1
                     attr_reg[line_reg][`ACF_STREAM_BIT] & ~sd_mode,
                     left_reg == 10'h001}; // see R2, R3
    end

    wire push = (wstate_reg == W_PUSH) & buf_in_ready;

    always @(posedge clk or posedge func_reset) begin
        if (func_reset) begin
            wstate_reg  <= W_IDLE;
            line_reg    <= 2'd0;
            left_reg    <= 10'h000;
            bptr_reg    <= 9'h000;
            rd_en_reg   <= 1'b0;
            insert_busy <= 1'b0;
        end else begin
            rd_en_reg <= 1'b0;
            case (wstate_reg)
                W_IDLE: begin
                    if (insert_start) begin
                        line_reg    <= 2'd0;
                        bptr_reg    <= 9'h000;
                        wstate_reg  <= W_LINE;
                        insert_busy <= 1'b1;
                    end
                end
                W_LINE: begin
                    if (line_cnt != 10'h000) begin
                        left_reg   <= line_cnt;
                        wstate_reg <= W_FETCH;
                    end else if (last_line) begin
                        wstate_reg  <= W_IDLE;
                        insert_busy <= 1'b0;
                    end else begin
                        line_reg <= line_reg + 2'd1;
                    end
                end
                W_FETCH: begin
                    rd_en_reg  <= 1'b1;
                    wstate_reg <= W_WAIT;
                end
                W_WAIT: begin
                    wstate_reg <= W_PUSH;
                end
                W_PUSH: begin
                    if (buf_in_ready) begin
                        bptr_reg <= bptr_reg + 9'h001; // see R16
                        left_reg <= left_reg - 10'h001;
                        if (left_reg != 10'h001) begin
                            wstate_reg <= W_FETCH;
                        end else if (last_line) begin
                            wstate_reg  <= W_IDLE;
                            insert_busy <= 1'b0;
                        end else begin
                            line_reg   <= line_reg + 2'd1; // see R16
                            wstate_reg <= W_LINE;
                        end
                    end
                end
                default: begin
                    wstate_reg  <= W_IDLE;
                    insert_busy <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************************************
    // Two-entry output buffer
    // ****************************************************************
    // The head entry drives the pins so outputs come from flops, and
    // the tail entry absorbs the word in flight when the sink stalls.
    reg        tail_valid_reg;
    reg [21:0] tail_reg;
    wire       pop = anc_valid & anc_ready;

    assign buf_in_ready = ~tail_valid_reg;

    always @(posedge clk or posedge func_reset) begin
        if (func_reset) begin
            tail_valid_reg    <= 1'b0;
            tail_reg          <= 22'h000000;
            anc_valid         <= 1'b0;
            anc_byte          <= 8'h00;
            anc_line_number   <= 11'h000;
            anc_space_select  <= 1'b0;
            anc_chroma_select <= 1'b0;
            anc_last          <= 1'b0;
        end else if (pop && tail_valid_reg) begin
            {anc_byte, anc_line_number, anc_space_select,
             anc_chroma_select, anc_last} <= tail_reg;
            tail_valid_reg <= 1'b0;
        end else if (push && (pop || !anc_valid)) begin
            {anc_byte, anc_line_number, anc_space_select,
             anc_chroma_select, anc_last} <= push_data;
            anc_valid <= 1'b1;
        end else if (push) begin
            tail_reg       <= push_data;
            tail_valid_reg <= 1'b1;
        end else if (pop) begin
            anc_valid <= 1'b0;
        end
    end

    // ****************************************************************
    // Output enable
    // ****************************************************************
    always @(posedge clk or posedge reset) begin
        if (reset)
            anc_out_oe <= 1'b0; // see R10
        else
            anc_out_oe <= ~scan_mode;
    end

endmodule // acf_line_config

// [rtl/acf_payload_mem.v]
// Purpose: Payload word store for the four insertion banks.
// Assumes: One write port from the host, one read port for the walker.
// Notes:   Read data come out of a register one cycle after rd_en.
`timescale 1ns/100ps

module acf_payload_mem (
    input  wire        clk,
    input  wire        wr_en,
    input  wire [7:0]  wr_addr,
    input  wire [15:0] wr_data,
    input  wire        rd_en,
    input  wire [7:0]  rd_addr,
    output reg  [15:0] rd_data
);

    reg [15:0] mem_reg [0:255];

    always @(posedge clk) begin
        if (wr_en) begin
            mem_reg[wr_addr] <= wr_data;
        end
        if (rd_en) begin
            rd_data <= mem_reg[rd_addr];
        end
    end

endmodule // acf_payload_mem

// [sim/acf_host_model.sv]
// Purpose: Host processor model for the serial host port.
// Assumes: Serial clock half period of four system clocks.
// Notes:   Data line is inverted between frames so it never idles stale.
`timescale 1ns/100ps

module acf_host_model (
    input  wire clk,
    output reg  host_cs_n,
    output reg  host_sclk,
    output reg  host_sdin,
    input  wire host_sdout,
    input  wire host_sdout_oe
);
    initial begin
        host_cs_n = 1'b1;
        host_sclk = 1'b0;
        host_sdin = 1'b0;
    end

    // Command word then data word, MSB first, read data sampled late.
    task xfer(input [15:0] cmd, input [15:0] wd, output [15:0] rd);
        integer    i;
        reg [31:0] fr;
        begin
            fr = {cmd, wd};
            rd = 16'h0000;
            @(negedge clk);
            host_cs_n = 1'b0;
            for (i = 31; i >= 0; i = i - 1) begin
                host_sclk = 1'b0;
                host_sdin = fr[i];
                repeat (4) @(negedge clk);
                if (i < 16)
                    rd[i] = host_sdout;
                host_sclk = 1'b1;
                repeat (4) @(negedge clk);
            end
            repeat (6) @(negedge clk);
            host_sclk = 1'b0;
            host_cs_n = 1'b1;
            host_sdin = ~host_sdin;
            repeat (4) @(negedge clk);
        end
    endtask
endmodule // acf_host_model

// [sim/acf_line_config_assertions.sv]
// Purpose: Concurrent checks on the line config store ports.
// Assumes: One clock domain; reset is asynchronous, active high.
// Notes:   Attached to every instance of the store by bind.
`timescale 1ns/100ps

module acf_line_config_chk (
    input wire        clk,
    input wire        reset,
    input wire        host_cs_n,
    input wire        host_sdout_oe,
    input wire        test_select,
    input wire        definition_rate_select,
    input wire        insert_start,
    input wire        anc_ready,
    input wire        anc_valid,
    input wire [7:0]  anc_byte,
    input wire [10:0] anc_line_number,
    input wire        anc_chroma_select,
    input wire        anc_last,
    input wire        anc_out_oe,
    input wire        insert_busy
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    AST_RST_OE: assert property (
        $fell(reset) |-> !anc_out_oe && !host_sdout_oe && !anc_valid)
        else $error("outputs driven while reset held");
    AST_OE_UP: assert property (
        $fell(reset) && !test_select |=> anc_out_oe)
        else $error("outputs not enabled after reset");
    AST_SCAN: assert property (
        test_select [*4] |=> !anc_out_oe)
        else $error("stream outputs driven in scan mode");
    AST_HOLD: assert property (
        anc_valid && !anc_ready |=> anc_valid && $stable(anc_byte)
            && $stable(anc_line_number) && $stable(anc_last))
        else $error("stream word changed while stalled");
    AST_VALID_BUSY: assert property (
        !insert_busy && !anc_valid |=> !anc_valid)
        else $error("stream word outside a walk");
    AST_GAP: assert property (
        anc_valid && anc_ready |=> !(anc_valid && anc_ready) [*2])
        else $error("stream words closer than three cycles");
    AST_START: assert property (
        insert_start && !insert_busy |=> insert_busy)
        else $error("start did not begin a walk");
    AST_FIRST: assert property (
        $rose(insert_busy) |-> !anc_valid [*3])
        else $error("first word too early");
    AST_SD: assert property (
        anc_valid && definition_rate_select |-> !anc_chroma_select)
        else $error("chroma selected in standard definition");
    AST_CS_OE: assert property (
        $rose(host_cs_n) && !test_select |-> ##[0:5] !host_sdout_oe)
        else $error("serial output still driven after deselect");
endmodule // acf_line_config_chk

bind acf_line_config acf_line_config_chk chk_u (
    .clk(clk), .reset(reset), .host_cs_n(host_cs_n),
    .host_sdout_oe(host_sdout_oe), .test_select(test_select),
    .definition_rate_select(definition_rate_select),
    .insert_start(insert_start), .anc_ready(anc_ready),
    .anc_valid(anc_valid), .anc_byte(anc_byte),
    .anc_line_number(anc_line_number),
    .anc_chroma_select(anc_chroma_select), .anc_last(anc_last),
    .anc_out_oe(anc_out_oe), .insert_busy(insert_busy)
);

// [sim/tb.sv]
// Purpose: Self-checking bench for the insertion line config store.
// Assumes: Host model drives the port; the bench acts as stream sink.
// Notes:   Reset is held 6 cycles; the real part needs far longer.
`timescale 1ns/100ps

module tb;
    reg         clk;
    reg         reset;
    reg         test_select;
    reg         definition_rate_select;
    reg         insert_start;
    reg         anc_ready;
    wire        host_cs_n, host_sclk, host_sdin, host_sdout;
    wire        host_sdout_oe, anc_valid, anc_space_select;
    wire        anc_chroma_select, anc_last, anc_out_oe, insert_busy;
    wire [7:0]  anc_byte;
    wire [10:0] anc_line_number;
    integer     bad_count, tests_run, cycles, k;
    reg  [40:0] rows [0:9];
    reg  [24:0] cfg [0:8];
    reg  [15:0] q;

    acf_line_config dut_u (
        .clk(clk), .reset(reset), .host_cs_n(host_cs_n),
        .host_sclk(host_sclk), .host_sdin(host_sdin),
        .host_sdout(host_sdout), .host_sdout_oe(host_sdout_oe),
        .test_select(test_select),
        .definition_rate_select(definition_rate_select),
        .insert_start(insert_start), .anc_ready(anc_ready),
        .anc_valid(anc_valid), .anc_byte(anc_byte),
        .anc_line_number(anc_line_number),
        .anc_space_select(anc_space_select),
        .anc_chroma_select(anc_chroma_select), .anc_last(anc_last),
        .anc_out_oe(anc_out_oe), .insert_busy(insert_busy)
    );

    acf_host_model hm_u (
        .clk(clk), .host_cs_n(host_cs_n), .host_sclk(host_sclk),
        .host_sdin(host_sdin), .host_sdout(host_sdout),
        .host_sdout_oe(host_sdout_oe)
    );

    task chk(input [63:0] nm, input [15:0] exp, input [15:0] got);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("[ERR] %0s exp %h got %h", nm, exp, got);
            end
        end
    endtask

    task wr(input [8:0] a, input [15:0] d);
        reg [15:0] dummy;
        begin
            hm_u.xfer({7'h00, a}, d, dummy);
        end
    endtask

    task rd(input [8:0] a, output [15:0] d);
        begin
            hm_u.xfer({7'h40, a}, 16'h0000, d);
        end
    endtask

    // The sink stalls two cycles on every byte to exercise the buffer.
    task walk(input hd, input conc);
        integer   i, n, t;
        reg [2:0] ea;
        begin
            n = conc ? 3 : 5;
            repeat (4) @(negedge clk);
            insert_start = 1'b1;
            @(negedge clk);
            insert_start = 1'b0;
            for (i = 0; i < n; i = i + 1) begin
                t = 0;
                while (anc_valid !== 1'b1 && t < 100) begin
                    @(negedge clk);
                    t = t + 1;
                end
                repeat (2) @(negedge clk);
                ea = {i < 3, hd && i < 3, i == 2 || i == 4};
                chk("byte", 8'h11 * (i + 1), {8'h00, anc_byte});
                chk("line", (i < 3) ? 16'h000a : 16'h0005,
                    {5'h00, anc_line_number});
                chk("attr", {13'h0000, ea}, {13'h0000, anc_space_select,
                    anc_chroma_select, anc_last});
                anc_ready = 1'b1;
                @(negedge clk);
                anc_ready = 1'b0;
                if (i == 0) begin
                    insert_start = 1'b1;
                    @(negedge clk);
                    insert_start = 1'b0;
                end
            end
            repeat (12) @(negedge clk);
            chk("busy", 16'h0000, {15'h0000, insert_busy});
        end
    endtask

    task report_and_stop;
        begin
            $display("checks %0d errors %0d", tests_run, bad_count);
            if (bad_count == 0 && tests_run > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles > 30000) begin
            bad_count = bad_count + 1;
            report_and_stop;
        end
    end

    initial begin
        reset = 1'b1;
        test_select = 1'b0;
        definition_rate_select = 1'b0;
        insert_start = 1'b0;
        anc_ready = 1'b0;
        bad_count = 0;
        tests_run = 0;
        cycles = 0;
        rows[0] = {9'h020, 16'hffff, 16'h9fff};
        rows[1] = {9'h021, 16'hffff, 16'hffff};
        rows[2] = {9'h022, 16'ha5a5, 16'ha5a5};
        rows[3] = {9'h023, 16'h5a5a, 16'h5a5a};
        rows[4] = {9'h024, 16'h0123, 16'h0123};
        rows[5] = {9'h026, 16'h89ab, 16'h89ab};
        rows[6] = {9'h040, 16'h1234, 16'h0000};
        rows[7] = {9'h13f, 16'habcd, 16'h0000};
        rows[8] = {9'h140, 16'hffff, 16'h0000};
        rows[9] = {9'h01f, 16'hffff, 16'h0000};
        cfg[0] = {9'h020, 16'h000a};
        cfg[1] = {9'h021, 16'hc003};
        cfg[2] = {9'h022, 16'h0005};
        cfg[3] = {9'h023, 16'h0002};
        cfg[4] = {9'h025, 16'h0000};
        cfg[5] = {9'h027, 16'h0000};
        cfg[6] = {9'h040, 16'h1122};
        cfg[7] = {9'h041, 16'h3344};
        cfg[8] = {9'h042, 16'h5566};
        repeat (6) @(negedge clk);
        chk("oe_rst", 16'h0000, {15'h0000, anc_out_oe});
        reset = 1'b0;
        repeat (4) @(negedge clk);
        chk("oe_run", 16'h0001, {15'h0000, anc_out_oe});
        for (k = 32; k < 40; k = k + 1) begin
            rd(k[8:0], q);
            chk("defval", 16'h0000, q);
        end
        for (k = 0; k < 10; k = k + 1) begin
            wr(rows[k][40:32], rows[k][31:16]);
            rd(rows[k][40:32], q);
            chk("reg", rows[k][15:0], q);
        end
        for (k = 0; k < 9; k = k + 1)
            wr(cfg[k][24:16], cfg[k][15:0]);
        walk(1'b1, 1'b0);
        definition_rate_select = 1'b1;
        walk(1'b0, 1'b0);
        definition_rate_select = 1'b0;
        wr(9'h020, 16'h800a);
        walk(1'b1, 1'b1);
        test_select = 1'b1;
        repeat (6) @(negedge clk);
        chk("oe_scan", 16'h0001,
            {14'h0000, anc_out_oe, host_sdout_oe});
        hm_u.xfer(16'h0001, 16'h8421, q);
        chk("bypass", 16'hc210, q);
        reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        repeat (2) @(negedge clk);
        test_select = 1'b0;
        repeat (6) @(negedge clk);
        rd(9'h022, q);
        chk("scan_rst", 16'h0005, q);
        reset = 1'b1;
        repeat (6) @(negedge clk);
        chk("oe_host", 16'h0000,
            {14'h0000, anc_out_oe, host_sdout_oe});
        reset = 1'b0;
        repeat (4) @(negedge clk);
        rd(9'h022, q);
        chk("cleared", 16'h0000, q);
        report_and_stop;
    end
endmodule // tb
